// file: design/waveform_dead_time_generator.sv
// waveform channel: timer-gated pulse mode and two dead-time modes, with apb registers
`timescale 1ns/1ps
`include "wave_dead_time_regs.svh"

module waveform_dead_time_generator (
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  input  wire logic        cmp_in0,
  input  wire logic        cmp_in1,
  input  wire logic        pulse_in,
  output logic             wave_out0,
  output logic             wave_out1,
  output logic             pulse_gate_out
);
  import wave_dead_time_pkg::*;

  state_type s_reg;
  state_type s_next;
  logic      wr_ok;
  logic      entry;
  logic      tick;
  logic      t_exp;
  logic      p_exp;
  logic      rise0;
  logic      rise1;
  logic      fall1;
  logic      dt_rise;
  logic      dt_fall;

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == `ADDR_CHANNEL_CONFIG) || (a == `ADDR_DEAD_TIME_A) ||
           (a == `ADDR_DEAD_TIME_B) || (a == `ADDR_FILTER_WIDTH) || (a == `ADDR_STATUS);
  endfunction

  // which output a two-bit selector touches: idx 0 is output 0
  function automatic logic sel_hits(input logic [1:0] sel, input logic idx);
    return (sel == 2'b11) || (idx ? (sel == 2'b10) : (sel == 2'b01));
  endfunction

  // polarity 01 inverts both, 10 only output 0, 11 only output 1
  function automatic logic pol_inv(input logic [1:0] sel, input logic idx);
    return (sel == 2'b01) || (idx ? (sel == 2'b11) : (sel == 2'b10));
  endfunction

  function automatic logic [31:0] read_word(input state_type st, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `ADDR_CHANNEL_CONFIG: begin
        d[`CFG_MODE_MSB:`CFG_MODE_LSB]         = st.cfg.op_mode_sel;
        d[`CFG_GATE_MSB:`CFG_GATE_LSB]         = st.cfg.gate_select;
        d[`CFG_APPLY_MSB:`CFG_APPLY_LSB]       = st.cfg.pulse_apply_select;
        d[`CFG_POL_MSB:`CFG_POL_LSB]           = st.cfg.polarity_select;
        d[`CFG_PRESCALE_MSB:`CFG_PRESCALE_LSB] = st.cfg.prescale;
      end
      `ADDR_DEAD_TIME_A:  d[15:0] = st.dead_time_a_value;
      `ADDR_DEAD_TIME_B:  d[15:0] = st.dead_time_b_value;
      `ADDR_FILTER_WIDTH: d[15:0] = st.filter_width_value;
      `ADDR_STATUS: d[6:0] = {st.pcnt_run, st.timer_run, st.gate, st.wave1, st.wave0,
                              st.flag1, st.flag0};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    s_next  = s_reg;
    entry   = 1'b0;
    dt_rise = 1'b0;
    dt_fall = 1'b0;
    // one wait state: pready rises in the second access cycle
    wr_ok = psel_in && penable_in && s_reg.pready && pwrite_in;
    s_next.pready  = psel_in && penable_in && !s_reg.pready;
    s_next.pslverr = 1'b0;
    if (psel_in && penable_in && !s_reg.pready) begin
      s_next.prdata  = pwrite_in ? 32'h0000_0000 : read_word(s_reg, paddr_in);
      s_next.pslverr = !addr_mapped(paddr_in);
    end
    if (wr_ok) begin
      case (paddr_in)
        `ADDR_CHANNEL_CONFIG: begin
          s_next.cfg.op_mode_sel        = pwdata_in[`CFG_MODE_MSB:`CFG_MODE_LSB];
          s_next.cfg.gate_select        = pwdata_in[`CFG_GATE_MSB:`CFG_GATE_LSB];
          s_next.cfg.pulse_apply_select = pwdata_in[`CFG_APPLY_MSB:`CFG_APPLY_LSB];
          s_next.cfg.polarity_select    = pwdata_in[`CFG_POL_MSB:`CFG_POL_LSB];
          s_next.cfg.prescale           = pwdata_in[`CFG_PRESCALE_MSB:`CFG_PRESCALE_LSB];
          entry = (pwdata_in[`CFG_MODE_MSB:`CFG_MODE_LSB] != s_reg.cfg.op_mode_sel);
        end
        `ADDR_DEAD_TIME_A:  s_next.dead_time_a_value  = pwdata_in[15:0];
        `ADDR_DEAD_TIME_B:  s_next.dead_time_b_value  = pwdata_in[15:0];
        `ADDR_FILTER_WIDTH: s_next.filter_width_value = pwdata_in[15:0];
        default: ;
      endcase
    end

    // ****************************************
    // divided channel clock and counters
    // ****************************************
    tick = (s_reg.pre_cnt == s_reg.cfg.prescale);
    s_next.pre_cnt = tick ? 8'h00 : s_reg.pre_cnt + 8'h01;
    // expiry on the tick that brings the count to zero; a load of 0 expires as 1
    t_exp = tick && s_reg.timer_run && (s_reg.timer <= 16'h0001);
    p_exp = tick && s_reg.pcnt_run && (s_reg.pcnt <= 16'h0001);
    if (tick && s_reg.timer_run) begin
      s_next.timer = s_reg.timer - 16'h0001;
      s_next.timer_run = !t_exp;
    end
    if (tick && s_reg.pcnt_run) begin
      s_next.pcnt = s_reg.pcnt - 16'h0001;
      s_next.pcnt_run = !p_exp;
    end
    s_next.cmp0_q = cmp_in0;
    s_next.cmp1_q = cmp_in1;
    rise0 = cmp_in0 && !s_reg.cmp0_q;
    rise1 = cmp_in1 && !s_reg.cmp1_q;
    fall1 = !cmp_in1 && s_reg.cmp1_q;

    // ****************************************
    // mode logic
    // ****************************************
    case (s_next.cfg.op_mode_sel)
      `MODE_TIMER_GATED: begin
        // expiry is handled first so that a new edge in the same cycle wins
        if (t_exp) begin
          s_next.flag0 = 1'b0;
          s_next.flag1 = 1'b0;
        end
        if (rise0) begin
          s_next.flag0 = 1'b1;
        end
        if (rise1) begin
          s_next.flag1 = 1'b1;
        end
        if (rise0 || rise1) begin
          // a only wins when both rise together; reload restarts the shared count
          s_next.timer = rise0 ? s_reg.dead_time_a_value : s_reg.dead_time_b_value;
          s_next.timer_run = 1'b1;
        end
      end
      `MODE_DEAD, `MODE_DEAD_FILTER: begin
        if (s_next.cfg.op_mode_sel == `MODE_DEAD) begin
          dt_rise = rise1;
          dt_fall = fall1;
        end else begin
          if (p_exp && (cmp_in1 != s_reg.filt)) begin
            s_next.filt = cmp_in1;
            dt_rise = cmp_in1;
            dt_fall = !cmp_in1;
          end
          // a short pulse is undone before expiry, so the level matches: discarded
          if (rise1 || fall1) begin
            s_next.pcnt = s_reg.filter_width_value;
            s_next.pcnt_run = 1'b1;
          end
        end
        if (t_exp) begin
          if (s_reg.rise_pending) begin
            s_next.raw0 = 1'b1;
          end else begin
            s_next.raw1 = 1'b1;
          end
        end
        // a new edge restarts the dead time, so an unfinished rise never raises out0
        if (dt_rise) begin
          s_next.raw1 = 1'b0;
          s_next.timer = s_reg.dead_time_b_value;
          s_next.timer_run = 1'b1;
          s_next.rise_pending = 1'b1;
        end
        if (dt_fall) begin
          s_next.raw0 = 1'b0;
          s_next.timer = s_reg.dead_time_a_value;
          s_next.timer_run = 1'b1;
          s_next.rise_pending = 1'b0;
        end
      end
      default: begin
        // unsupported modes park the channel with flags and raw levels low; polarity still applies to the outputs
        s_next.flag0 = 1'b0;
        s_next.flag1 = 1'b0;
        s_next.raw0 = 1'b0;
        s_next.raw1 = 1'b0;
        s_next.timer_run = 1'b0;
        s_next.pcnt_run = 1'b0;
      end
    endcase

    if (entry) begin
      s_next.timer_run = 1'b0;
      s_next.pcnt_run = 1'b0;
      s_next.flag0 = 1'b0;
      s_next.flag1 = 1'b0;
      s_next.filt = cmp_in1;
      s_next.raw0 = cmp_in1;
      s_next.raw1 = !cmp_in1;
      s_next.rise_pending = cmp_in1;
    end

    // ****************************************
    // output shaping
    // ****************************************
    s_next.gate = 1'b0;
    if (s_next.cfg.op_mode_sel == `MODE_TIMER_GATED) begin
      s_next.raw0 = s_next.flag0 &&
                    (!sel_hits(s_next.cfg.pulse_apply_select, 1'b0) || pulse_in);
      s_next.raw1 = s_next.flag1 &&
                    (!sel_hits(s_next.cfg.pulse_apply_select, 1'b1) || pulse_in);
      s_next.gate = (sel_hits(s_next.cfg.gate_select, 1'b0) && s_next.flag0) ||
                    (sel_hits(s_next.cfg.gate_select, 1'b1) && s_next.flag1);
    end
    // polarity is applied last, after every mode
    s_next.wave0 = s_next.raw0 ^ pol_inv(s_next.cfg.polarity_select, 1'b0);
    s_next.wave1 = s_next.raw1 ^ pol_inv(s_next.cfg.polarity_select, 1'b1);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s_reg <= '0;
      s_reg.cfg.op_mode_sel <= `MODE_THROUGH;
      s_reg.cfg.gate_select <= `RST_SEL;
      s_reg.cfg.pulse_apply_select <= `RST_SEL;
      s_reg.cfg.polarity_select <= `RST_SEL;
      s_reg.cfg.prescale <= `RST_PRESCALE;
      s_reg.dead_time_a_value <= `RST_TIME;
      s_reg.dead_time_b_value <= `RST_TIME;
      s_reg.filter_width_value <= `RST_TIME;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pready_out     = s_reg.pready;
  assign pslverr_out    = s_reg.pslverr;
  assign prdata_out     = s_reg.prdata;
  assign wave_out0      = s_reg.wave0;
  assign wave_out1      = s_reg.wave1;
  assign pulse_gate_out = s_reg.gate;

  // ****************************************
  // assertions
  // ****************************************
  timer_entry_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (entry && s_next.cfg.op_mode_sel == `MODE_TIMER_GATED) |=>
      (!s_reg.flag0 && !s_reg.flag1 && !s_reg.raw0 && !s_reg.raw1))
    else $error("timer mode entry did not clear flags and outputs");

  flag0_set_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!wr_ok && s_reg.cfg.op_mode_sel == `MODE_TIMER_GATED && rise0 && !rise1) |=>
      (s_reg.flag0 && s_reg.timer_run && s_reg.timer == $past(s_reg.dead_time_a_value)))
    else $error("rising cmp_in0 did not set flag 0 and load a");

  flag1_set_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!wr_ok && s_reg.cfg.op_mode_sel == `MODE_TIMER_GATED && rise1 && !rise0) |=>
      (s_reg.flag1 && s_reg.timer == $past(s_reg.dead_time_b_value)))
    else $error("rising cmp_in1 did not set flag 1 and load b");

  both_rise_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!wr_ok && s_reg.cfg.op_mode_sel == `MODE_TIMER_GATED && rise0 && rise1) |=>
      (s_reg.flag0 && s_reg.flag1 && s_reg.timer == $past(s_reg.dead_time_a_value)))
    else $error("simultaneous edges did not load a with both flags");

  flags_expire_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!wr_ok && s_reg.cfg.op_mode_sel == `MODE_TIMER_GATED && t_exp && !rise0 && !rise1) |=>
      (!s_reg.flag0 && !s_reg.flag1 && !s_reg.timer_run))
    else $error("timer expiry did not clear both flags");

  dead_gate_low_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (s_reg.cfg.op_mode_sel == `MODE_DEAD || s_reg.cfg.op_mode_sel == `MODE_DEAD_FILTER) |->
      !pulse_gate_out)
    else $error("gate output high in a dead-time mode");

  dead_entry_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (entry && s_next.cfg.op_mode_sel == `MODE_DEAD) |=>
      (s_reg.raw0 == $past(cmp_in1) && s_reg.raw1 == !$past(cmp_in1)))
    else $error("dead-time entry levels wrong");

  dead_rise_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!wr_ok && s_reg.cfg.op_mode_sel == `MODE_DEAD && rise1) |=>
      (!s_reg.raw1 && s_reg.rise_pending && s_reg.timer == $past(s_reg.dead_time_b_value)))
    else $error("rising cmp_in1 did not start dead time b");

  dead_fall_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!wr_ok && s_reg.cfg.op_mode_sel == `MODE_DEAD && fall1) |=>
      (!s_reg.raw0 && !s_reg.rise_pending && s_reg.timer == $past(s_reg.dead_time_a_value)))
    else $error("falling cmp_in1 did not start dead time a");

  no_overlap_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (s_reg.cfg.op_mode_sel == `MODE_DEAD && $past(s_reg.cfg.op_mode_sel) == `MODE_DEAD) |->
      !(s_reg.raw0 && s_reg.raw1))
    else $error("complementary outputs overlap");

  filter_drop_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!wr_ok && s_reg.cfg.op_mode_sel == `MODE_DEAD_FILTER && p_exp &&
     cmp_in1 == s_reg.filt && !t_exp) |=>
      ($stable(s_reg.raw0) && $stable(s_reg.raw1)))
    else $error("short pulse changed filtered outputs");

  polarity_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (s_reg.cfg.polarity_select == 2'b10) |-> (wave_out0 != s_reg.raw0 && wave_out1 == s_reg.raw1))
    else $error("polarity select 10 not applied");

  both_flags_c: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    s_reg.cfg.op_mode_sel == `MODE_TIMER_GATED && s_reg.flag0 && s_reg.flag1 && pulse_gate_out);

  dead_done_c: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    s_reg.cfg.op_mode_sel == `MODE_DEAD && t_exp && s_reg.rise_pending);

  filter_discard_c: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    s_reg.cfg.op_mode_sel == `MODE_DEAD_FILTER && p_exp && cmp_in1 == s_reg.filt);

endmodule // waveform_dead_time_generator

// file: design/wave_dead_time_regs.svh
// register offsets, field positions, reset values and mode codes of the waveform channel
`ifndef WAVE_DEAD_TIME_REGS_SVH
`define WAVE_DEAD_TIME_REGS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_CHANNEL_CONFIG 8'h00
`define ADDR_DEAD_TIME_A    8'h04
`define ADDR_DEAD_TIME_B    8'h08
`define ADDR_FILTER_WIDTH   8'h0c
`define ADDR_STATUS         8'h10

// ****************************************
// channel_config_reg field positions
// ****************************************
`define CFG_MODE_LSB      0
`define CFG_MODE_MSB      2
`define CFG_GATE_LSB      4
`define CFG_GATE_MSB      5
`define CFG_APPLY_LSB     8
`define CFG_APPLY_MSB     9
`define CFG_POL_LSB       12
`define CFG_POL_MSB       13
`define CFG_PRESCALE_LSB  16
`define CFG_PRESCALE_MSB  23

// ****************************************
// mode codes and reset values
// ****************************************
`define MODE_THROUGH      3'b000
`define MODE_TIMER_GATED  3'b010
`define MODE_DEAD         3'b100
`define MODE_DEAD_FILTER  3'b101
`define RST_TIME          16'h0000
`define RST_PRESCALE      8'h00
`define RST_SEL           2'b00

`endif

// file: design/wave_dead_time_pkg.sv
// types shared by the waveform dead-time channel
package wave_dead_time_pkg;
`include "wave_dead_time_regs.svh"

  typedef enum logic [2:0] {
    MODE_THROUGH_E     = `MODE_THROUGH,
    MODE_TIMER_GATED_E = `MODE_TIMER_GATED,
    MODE_DEAD_E        = `MODE_DEAD,
    MODE_DEAD_FILTER_E = `MODE_DEAD_FILTER
  } op_mode_type;

  typedef struct packed {
    logic [7:0] prescale;
    logic [1:0] polarity_select;
    logic [1:0] pulse_apply_select;
    logic [1:0] gate_select;
    logic [2:0] op_mode_sel;
  } config_type;

  typedef struct packed {
    config_type  cfg;
    logic [15:0] dead_time_a_value;
    logic [15:0] dead_time_b_value;
    logic [15:0] filter_width_value;
    logic [7:0]  pre_cnt;
    logic [15:0] timer;
    logic        timer_run;
    logic        rise_pending;
    logic [15:0] pcnt;
    logic        pcnt_run;
    logic        filt;
    logic        flag0;
    logic        flag1;
    logic        cmp0_q;
    logic        cmp1_q;
    logic        raw0;
    logic        raw1;
    logic        wave0;
    logic        wave1;
    logic        gate;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_type;
endpackage

// file: test/cmp_pulse_model.sv
// behavioural compare unit and pulse generator feeding the channel inputs
`timescale 1ns/1ps
module cmp_pulse_model (
  output logic cmp0_out,
  output logic cmp1_out,
  output logic pulse_out
);
  initial begin
    cmp0_out  = 1'b0;
    cmp1_out  = 1'b0;
    pulse_out = 1'b0;
  end
  // ****************************************
  // line drive
  // ****************************************
  // called right after a rising edge; nba so the channel samples it one edge later
  task automatic drive(input logic c0, input logic c1, input logic p);
    cmp0_out  <= c0;
    cmp1_out  <= c1; // compare match holds the line high
    pulse_out <= p;
  endtask
endmodule // cmp_pulse_model

// file: test/test_waveform_dead_time_generator.sv
// self-checking bench for the waveform dead-time channel
`timescale 1ns/1ps
`include "wave_dead_time_regs.svh"
module test_waveform_dead_time_generator;
  import wave_dead_time_pkg::*;
  logic        sys_clk_in  = 1'b0;
  logic        srst_in     = 1'b1;
  logic        psel_in     = 1'b0;
  logic        penable_in  = 1'b0;
  logic        pwrite_in   = 1'b0;
  logic [7:0]  paddr_in    = 8'h00;
  logic [31:0] pwdata_in   = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, cmp_in0, cmp_in1, pulse_in;
  logic        wave_out0, wave_out1, pulse_gate_out;
  int          err_total   = 0;
  int          comparisons = 0;

  always #20 sys_clk_in = ~sys_clk_in;

  waveform_dead_time_generator dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .prdata_out(prdata_out), .cmp_in0(cmp_in0), .cmp_in1(cmp_in1), .pulse_in(pulse_in),
    .wave_out0(wave_out0), .wave_out1(wave_out1), .pulse_gate_out(pulse_gate_out));
  cmp_pulse_model far_end (.cmp0_out(cmp_in0), .cmp1_out(cmp_in1), .pulse_out(pulse_in));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // one apb transfer; entered just after a rising edge, leaves one edge after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    // no fixed wait assumed; a missing answer is left to the watchdog
    do begin
      @(posedge sys_clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic cfg(input op_mode_type m, input logic [1:0] g, a, p);
    wr(`ADDR_CHANNEL_CONFIG, {18'h0, p, 2'b00, a, 2'b00, g, 1'b0, m});
  endtask
  task automatic outs(input string s, input logic e0, input logic e1);
    chk({s, " wave0"}, wave_out0, e0);
    chk({s, " wave1"}, wave_out1, e1);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    apb(1'b0, `ADDR_CHANNEL_CONFIG, 32'h0, r, e);
    chk("config reset", r, 32'h0);
    wr(`ADDR_DEAD_TIME_A, 32'h6);
    wr(`ADDR_DEAD_TIME_B, 32'hc);
    wr(`ADDR_FILTER_WIDTH, 32'h8);
    apb(1'b0, `ADDR_DEAD_TIME_B, 32'h0, r, e);
    chk("dead b readback", r, 32'hc);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped error", e, 1'b1);
    chk("unmapped data", r, 32'h0);
    $display("done regs");
  endtask
  task automatic t_entry();
    far_end.drive(1'b1, 1'b1, 1'b1);
    cyc(3);
    outs("parked", 1'b0, 1'b0);
    cfg(MODE_TIMER_GATED_E, 2'b11, 2'b00, 2'b00);
    cyc(4);
    outs("entry", 1'b0, 1'b0);
    chk("entry gate", pulse_gate_out, 1'b0);
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(2);
    // flag 0 is cleared by the entry into dead-time mode, before its timer can expire
    far_end.drive(1'b1, 1'b0, 1'b1);
    cyc(1);
    cfg(MODE_DEAD_E, 2'b11, 2'b00, 2'b00);
    outs("dead visit", 1'b0, 1'b1);
    cfg(MODE_TIMER_GATED_E, 2'b11, 2'b00, 2'b00);
    cyc(1);
    outs("flags cleared", 1'b0, 1'b0);
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(2);
    $display("done entry");
  endtask
  task automatic t_gate();
    for (int g = 0; g < 4; g++) begin
      cfg(MODE_TIMER_GATED_E, g[1:0], 2'b00, 2'b00);
      far_end.drive(1'b1, 1'b0, 1'b0);
      cyc(1);
      far_end.drive(1'b0, 1'b0, 1'b0);
      cyc(2);
      outs("flag0 set", 1'b1, 1'b0);
      chk("gate flag0", pulse_gate_out, g[0]);
      cyc(2);
      chk("flag0 held", wave_out0, 1'b1);
      cyc(7);
      chk("flag0 expired", wave_out0, 1'b0);
      far_end.drive(1'b0, 1'b1, 1'b0);
      cyc(3);
      outs("flag1 set", 1'b0, 1'b1);
      chk("gate flag1", pulse_gate_out, g[1]);
      cyc(7);
      chk("flag1 held", wave_out1, 1'b1);
      cyc(8);
      chk("flag1 expired", wave_out1, 1'b0);
      far_end.drive(1'b0, 1'b0, 1'b0);
      cyc(2);
    end
    $display("done gate");
  endtask
  task automatic t_overlap();
    far_end.drive(1'b1, 1'b1, 1'b0);
    cyc(1);
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(4);
    outs("both set", 1'b1, 1'b1);
    cyc(7);
    outs("both from a", 1'b0, 1'b0);
    far_end.drive(1'b1, 1'b0, 1'b0);
    cyc(1);
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(2);
    far_end.drive(1'b0, 1'b1, 1'b0);
    cyc(1);
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(10);
    outs("lengthened", 1'b1, 1'b1);
    cyc(10);
    outs("joint clear", 1'b0, 1'b0);
    $display("done overlap");
  endtask
  task automatic t_apply();
    for (int a = 0; a < 4; a++) begin
      cfg(MODE_TIMER_GATED_E, 2'b11, a[1:0], 2'b00);
      far_end.drive(1'b1, 1'b1, 1'b0);
      cyc(1);
      far_end.drive(1'b0, 1'b0, 1'b0);
      cyc(2);
      outs("apply pulse low", !a[0], !a[1]);
      far_end.drive(1'b0, 1'b0, 1'b1);
      cyc(3);
      outs("apply pulse high", 1'b1, 1'b1);
      far_end.drive(1'b0, 1'b0, 1'b0);
      cyc(8);
    end
    $display("done apply");
  endtask
  task automatic t_polarity();
    for (int p = 0; p < 4; p++) begin
      cfg(MODE_TIMER_GATED_E, 2'b00, 2'b00, p[1:0]);
      cyc(2);
      outs("polarity", p == 1 || p == 2, p == 1 || p == 3);
    end
    $display("done polarity");
  endtask
  task automatic t_dead();
    logic hi;
    far_end.drive(1'b0, 1'b1, 1'b0);
    cyc(2);
    cfg(MODE_DEAD_E, 2'b11, 2'b11, 2'b00);
    cyc(2);
    outs("dead entry", 1'b1, 1'b0);
    far_end.drive(1'b1, 1'b0, 1'b1);
    cyc(3);
    outs("fall at once", 1'b0, 1'b0);
    cyc(8);
    outs("fall dead a", 1'b0, 1'b1);
    chk("dead gate", pulse_gate_out, 1'b0);
    far_end.drive(1'b0, 1'b1, 1'b0);
    cyc(3);
    outs("rise at once", 1'b0, 1'b0);
    cyc(9);
    chk("rise waits b", wave_out0, 1'b0);
    cyc(5);
    outs("rise dead b", 1'b1, 1'b0);
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(12);
    far_end.drive(1'b0, 1'b1, 1'b0);
    cyc(4);
    far_end.drive(1'b0, 1'b0, 1'b0);
    hi = 1'b0;
    repeat (25) begin
      cyc(1);
      hi |= wave_out0;
    end
    chk("short high", {wave_out1, hi}, 2'b10);
    far_end.drive(1'b0, 1'b1, 1'b0);
    cyc(17);
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(3);
    far_end.drive(1'b0, 1'b1, 1'b0);
    hi = 1'b0;
    repeat (25) begin
      cyc(1);
      hi |= wave_out1;
    end
    chk("short low", {wave_out0, hi}, 2'b10);
    $display("done dead");
  endtask
  task automatic t_filter();
    logic [1:0] first;
    logic       moved;
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(12);
    cfg(MODE_DEAD_FILTER_E, 2'b11, 2'b00, 2'b00);
    cyc(2);
    outs("filter entry", 1'b0, 1'b1);
    first = {wave_out1, wave_out0};
    far_end.drive(1'b1, 1'b1, 1'b1);
    cyc(3);
    far_end.drive(1'b0, 1'b0, 1'b0);
    moved = 1'b0;
    repeat (20) begin
      cyc(1);
      moved |= ({wave_out1, wave_out0} !== first) || pulse_gate_out;
    end
    chk("short discarded", moved, 1'b0);
    far_end.drive(1'b0, 1'b1, 1'b0);
    cyc(7);
    chk("filtering high", wave_out1, 1'b1);
    cyc(6);
    outs("high accepted", 1'b0, 1'b0);
    cyc(6);
    chk("high waits b", wave_out0, 1'b0);
    cyc(9);
    outs("high dead b", 1'b1, 1'b0);
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(7);
    chk("filtering low", wave_out0, 1'b1);
    cyc(6);
    outs("low accepted", 1'b0, 1'b0);
    cyc(9);
    outs("low dead a", 1'b0, 1'b1);
    chk("filter gate", pulse_gate_out, 1'b0);
    $display("done filter");
  endtask
  task automatic t_prescale();
    // prescale 1: a tick every second clock, so dead time a of 6 spans 12 clocks
    wr(`ADDR_CHANNEL_CONFIG, 32'h0001_0002);
    far_end.drive(1'b1, 1'b0, 1'b0);
    cyc(1);
    far_end.drive(1'b0, 1'b0, 1'b0);
    cyc(10);
    chk("slow tick held", wave_out0, 1'b1);
    cyc(3);
    chk("slow tick expired", wave_out0, 1'b0);
    $display("done prescale");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (12) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(posedge sys_clk_in);
    t_regs();
    t_entry();
    t_gate();
    t_overlap();
    t_apply();
    t_polarity();
    t_dead();
    t_filter();
    t_prescale();
    stop_test();
  end
  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    err_total++;
    stop_test();
  end
endmodule // test_waveform_dead_time_generator
